/* File: shared/smso_consts.vh */
`ifndef SMSO_CONSTS_VH
`define SMSO_CONSTS_VH
// control modes
`define SMSO_MODE_POS 2'd0
`define SMSO_MODE_VEL 2'd1
`define SMSO_MODE_TRQ 2'd2
// parameter select codes
`define SMSO_SEL_ZS_THR 4'h0
`define SMSO_SEL_VBAND 4'h1
`define SMSO_SEL_VMIN 4'h2
`define SMSO_SEL_TBAND 4'h3
`define SMSO_SEL_TTGT 4'h4
`define SMSO_SEL_CPOS 4'h5
`define SMSO_SEL_PLIM 4'h6
`define SMSO_SEL_NLIM 4'h7
`define SMSO_SEL_HOME 4'h8
`define SMSO_SEL_ESTOP 4'h9
`define SMSO_SEL_CLAMP 4'hA
`define SMSO_SEL_TIMER 4'hB
// speeds in 0.01 rps, torque in 0.1 percent, position in pulses
`define SMSO_ZS_THR_DEF 32'h0000_0032
`define SMSO_ZS_THR_MIN 32'h0000_000A
`define SMSO_ZS_THR_MAX 32'h0000_00C8
`define SMSO_VBAND_DEF 32'h0000_000A
`define SMSO_VMIN_DEF 32'h0000_03E8
`define SMSO_SPD_MAX 32'h0000_2710
`define SMSO_TBAND_DEF 32'h0000_000A
`define SMSO_TRQ_MAX 32'h0000_0BB8
`define SMSO_TTGT_DEF 32'h0000_0000
`define SMSO_CPOS_DEF 32'h0000_2710
`define SMSO_CPOS_TOL 32'h0000_0064
`define SMSO_POS_FORBID 32'h8000_0000
`define SMSO_LIM_DEF 32'h0000_0000
`define SMSO_HOME_DEF 8'h01
`define SMSO_HOME_MIN 8'hFC
`define SMSO_HOME_MAX 8'h28
`define SMSO_ESTOP_DEF 4'h5
`define SMSO_ESTOP_MIN 4'h1
`define SMSO_ESTOP_MAX 4'h8
`define SMSO_CLAMP_DEF 1'b0
`define SMSO_TIMER_DEF 15'h000A
`define SMSO_TIMER_MAX 32'h0000_7530
`define SMSO_QCNT_SAT 15'h7FFF
// filter and timing
`define SMSO_FILT_SHIFT 4
`define SMSO_CLK_HZ 125000000
`define SMSO_TICK_MS 1
`endif

/* File: logic/smso_status.v */
`timescale 1ns/1ps
`include "smso_consts.vh"
// Notes on behaviour
// - zero-speed flag high when speed magnitude below threshold, default 0.5 rps
// - zero-speed flag low when speed magnitude above threshold
// - zero-speed judged in every mode, enabled or not
// - velocity mode: consistent flag after speed stays in band for timer
// - consistent flag drops as soon as speed leaves band
// - velocity mode: reached flag after filtered speed exceeds minimum longer than timer
// - reached flag low while filtered speed not above minimum
// - torque mode: reached flag after target hit and kept in band for timer
// - torque reached flag low when any qualifying condition fails
// - position coincidence flag when position within 100 pulses of setting
// - positive limit alarm moving forward at or beyond positive limit
// - negative limit alarm moving backward at or beyond negative limit
// - soft limits writable after power-on, back to zero at reset
// - homing method selector, -4 to 40, default 1
// - emergency-stop method 1 to 8, default 5, applied on stop input
// - zero-speed clamp enable bit, default off
// - one shared millisecond qualification timer, default 10, 0 to 30000
module smso_status #(
    parameter CYC_PER_MS = (`SMSO_CLK_HZ / 1000) * `SMSO_TICK_MS
) (
    input wire clk_sys,
    input wire srst,
    input wire [1:0] control_mode,
    input wire signed [31:0] motor_speed,
    input wire signed [31:0] speed_command,
    input wire signed [31:0] motor_torque,
    input wire signed [31:0] motor_position,
    input wire estop_input,
    input wire param_write,
    input wire [3:0] param_select,
    input wire [31:0] param_data,
    output reg zero_speed_flag,
    output reg velocity_consistent_flag,
    output reg velocity_reached_flag,
    output reg torque_reached_flag,
    output reg position_coincidence_flag,
    output reg positive_limit_alarm,
    output reg negative_limit_alarm,
    output reg [7:0] homing_method_select,
    output reg [3:0] estop_method_select,
    output reg [3:0] estop_method_applied,
    output reg zero_clamp_enable,
    output reg param_reject
);

    // magnitude of a signed word
    function [31:0] mag32;
        input [31:0] v;
        begin
            mag32 = v[31] ? (~v + 32'h0000_0001) : v;
        end
    endfunction

    // qualification count step, restart on lapse, saturating
    function [14:0] qual_step;
        input cond;
        input tick;
        input [14:0] cnt;
        begin
            if (!cond) begin
                qual_step = 15'h0000;
            end else if (tick && (cnt != `SMSO_QCNT_SAT)) begin
                qual_step = cnt + 15'h0001;
            end else begin
                qual_step = cnt;
            end
        end
    endfunction

    // stored parameters
    reg [31:0] zs_thr_reg;
    reg [31:0] vband_reg;
    reg [31:0] vmin_reg;
    reg [31:0] tband_reg;
    reg [31:0] ttgt_reg;
    reg signed [31:0] cpos_reg;
    reg signed [31:0] plim_reg;
    reg signed [31:0] nlim_reg;
    reg [14:0] timer_reg;

    // millisecond prescaler and qualification counts
    reg [31:0] pre_reg;
    reg tick_reg;
    reg [14:0] vc_cnt_reg;
    reg [14:0] at_cnt_reg;
    reg [14:0] tq_cnt_reg;
    reg tq_hit_reg;
    reg signed [31:0] filt_reg;

    // combinational terms
    wire [31:0] spd_abs;
    wire [31:0] trq_abs;
    wire [31:0] vdev;
    wire [31:0] tdev;
    wire [31:0] pdev;
    wire signed [31:0] fdiff;
    wire signed [31:0] filt_next;
    wire vel_mode;
    wire trq_mode;
    wire vc_cond;
    wire at_cond;
    wire tq_cond;
    wire [14:0] vc_next;
    wire [14:0] at_next;
    wire [14:0] tq_next;
    wire hit_next;
    wire [31:0] timer_ext;
    reg accept;

    // magnitudes and deviations, evaluated every cycle
    assign spd_abs = mag32(motor_speed);
    assign trq_abs = mag32(motor_torque);
    assign vdev = mag32(motor_speed - speed_command);
    assign tdev = (trq_abs >= ttgt_reg) ? (trq_abs - ttgt_reg) : (ttgt_reg - trq_abs);
    assign pdev = mag32(motor_position - cpos_reg);
    assign fdiff = $signed(spd_abs) - filt_reg;
    assign filt_next = filt_reg + (fdiff >>> `SMSO_FILT_SHIFT);
    assign vel_mode = (control_mode == `SMSO_MODE_VEL);
    assign trq_mode = (control_mode == `SMSO_MODE_TRQ);
    assign timer_ext = {17'h0_0000, timer_reg};

    // qualifying conditions
    assign vc_cond = vel_mode && (vdev <= vband_reg);
    assign at_cond = vel_mode && ($signed(filt_reg) > $signed(vmin_reg));
    assign hit_next = trq_mode && (tdev <= tband_reg) && (tq_hit_reg || (trq_abs >= ttgt_reg));
    assign tq_cond = hit_next;

    // counts restart whenever the condition lapses
    assign vc_next = qual_step(vc_cond, tick_reg, vc_cnt_reg);
    assign at_next = qual_step(at_cond, tick_reg, at_cnt_reg);
    assign tq_next = qual_step(tq_cond, tick_reg, tq_cnt_reg);

    // range check of a parameter write
    always @* begin
        accept = 1'b0;
        case (param_select)
            `SMSO_SEL_ZS_THR: begin
                accept = (param_data >= `SMSO_ZS_THR_MIN) && (param_data <= `SMSO_ZS_THR_MAX);
            end
            `SMSO_SEL_VBAND: begin
                accept = (param_data <= `SMSO_SPD_MAX);
            end
            `SMSO_SEL_VMIN: begin
                accept = (param_data <= `SMSO_SPD_MAX);
            end
            `SMSO_SEL_TBAND: begin
                accept = (param_data <= `SMSO_TRQ_MAX);
            end
            `SMSO_SEL_TTGT: begin
                accept = (param_data <= `SMSO_TRQ_MAX);
            end
            `SMSO_SEL_CPOS: begin
                accept = (param_data != `SMSO_POS_FORBID);
            end
            `SMSO_SEL_PLIM: begin
                accept = (param_data != `SMSO_POS_FORBID);
            end
            `SMSO_SEL_NLIM: begin
                accept = (param_data != `SMSO_POS_FORBID);
            end
            `SMSO_SEL_HOME: begin
                accept = ($signed(param_data) >= $signed({{24{1'b1}}, `SMSO_HOME_MIN}))
                    && ($signed(param_data) <= $signed({24'h00_0000, `SMSO_HOME_MAX}));
            end
            `SMSO_SEL_ESTOP: begin
                accept = (param_data >= {28'h000_0000, `SMSO_ESTOP_MIN})
                    && (param_data <= {28'h000_0000, `SMSO_ESTOP_MAX});
            end
            `SMSO_SEL_CLAMP: begin
                accept = (param_data[31:1] == 31'h0000_0000);
            end
            `SMSO_SEL_TIMER: begin
                accept = (param_data <= `SMSO_TIMER_MAX);
            end
            default: begin
                accept = 1'b0;
            end
        endcase
    end

    // parameter storage, defaults restored on reset
    always @(posedge clk_sys) begin
        if (srst) begin
            zs_thr_reg <= `SMSO_ZS_THR_DEF;
            vband_reg <= `SMSO_VBAND_DEF;
            vmin_reg <= `SMSO_VMIN_DEF;
            tband_reg <= `SMSO_TBAND_DEF;
            ttgt_reg <= `SMSO_TTGT_DEF;
            cpos_reg <= `SMSO_CPOS_DEF;
            plim_reg <= `SMSO_LIM_DEF;
            nlim_reg <= `SMSO_LIM_DEF;
            homing_method_select <= `SMSO_HOME_DEF;
            estop_method_select <= `SMSO_ESTOP_DEF;
            zero_clamp_enable <= `SMSO_CLAMP_DEF;
            timer_reg <= `SMSO_TIMER_DEF;
            param_reject <= 1'b0;
        end else begin
            param_reject <= param_write && !accept;
            if (param_write && accept) begin
                case (param_select)
                    `SMSO_SEL_ZS_THR: zs_thr_reg <= param_data;
                    `SMSO_SEL_VBAND: vband_reg <= param_data;
                    `SMSO_SEL_VMIN: vmin_reg <= param_data;
                    `SMSO_SEL_TBAND: tband_reg <= param_data;
                    `SMSO_SEL_TTGT: ttgt_reg <= param_data;
                    `SMSO_SEL_CPOS: cpos_reg <= param_data;
                    `SMSO_SEL_PLIM: plim_reg <= param_data;
                    `SMSO_SEL_NLIM: nlim_reg <= param_data;
                    `SMSO_SEL_HOME: homing_method_select <= param_data[7:0];
                    `SMSO_SEL_ESTOP: estop_method_select <= param_data[3:0];
                    `SMSO_SEL_CLAMP: zero_clamp_enable <= param_data[0];
                    `SMSO_SEL_TIMER: timer_reg <= param_data[14:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // shared millisecond tick for the qualification timer
    always @(posedge clk_sys) begin
        if (srst) begin
            pre_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (pre_reg >= (CYC_PER_MS - 1)) begin
            pre_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            pre_reg <= pre_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    // qualification counts, speed filter, torque target latch
    always @(posedge clk_sys) begin
        if (srst) begin
            vc_cnt_reg <= 15'h0000;
            at_cnt_reg <= 15'h0000;
            tq_cnt_reg <= 15'h0000;
            tq_hit_reg <= 1'b0;
            filt_reg <= 32'h0000_0000;
        end else begin
            vc_cnt_reg <= vc_next;
            at_cnt_reg <= at_next;
            tq_cnt_reg <= tq_next;
            tq_hit_reg <= hit_next;
            filt_reg <= filt_next;
        end
    end

    // status flags, all registered
    always @(posedge clk_sys) begin
        if (srst) begin
            zero_speed_flag <= 1'b0;
            velocity_consistent_flag <= 1'b0;
            velocity_reached_flag <= 1'b0;
            torque_reached_flag <= 1'b0;
            position_coincidence_flag <= 1'b0;
        end else begin
            // no mode or enable term here
            zero_speed_flag <= (spd_abs < zs_thr_reg);
            velocity_consistent_flag <= vc_cond && ({17'h0_0000, vc_next} >= timer_ext);
            velocity_reached_flag <= at_cond && ({17'h0_0000, at_next} > timer_ext);
            torque_reached_flag <= tq_cond && ({17'h0_0000, tq_next} >= timer_ext);
            position_coincidence_flag <= (pdev <= `SMSO_CPOS_TOL);
        end
    end

    // software limit alarms and stop method
    always @(posedge clk_sys) begin
        if (srst) begin
            positive_limit_alarm <= 1'b0;
            negative_limit_alarm <= 1'b0;
            estop_method_applied <= 4'h0;
        end else begin
            // direction from sign of measured speed
            positive_limit_alarm <= (motor_speed > 0) && (motor_position >= plim_reg);
            negative_limit_alarm <= (motor_speed < 0) && (motor_position <= nlim_reg);
            estop_method_applied <= estop_input ? estop_method_select : 4'h0;
        end
    end

endmodule // smso_status

/* File: bench/smso_status_properties.sv */
`timescale 1ns/1ps
`include "smso_consts.vh"
// status outputs tied to the inputs that cause them
module smso_status_properties (
    input wire clk_sys,
    input wire srst,
    input wire [1:0] control_mode,
    input wire signed [31:0] motor_speed,
    input wire signed [31:0] speed_command,
    input wire estop_input,
    input wire zero_speed_flag,
    input wire velocity_consistent_flag,
    input wire torque_reached_flag,
    input wire positive_limit_alarm,
    input wire negative_limit_alarm,
    input wire [3:0] estop_method_select,
    input wire [3:0] estop_method_applied
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // speed far from command, whatever the band setting
    sequence off_band_s;
        motor_speed - speed_command > 10000 || speed_command - motor_speed > 10000;
    endsequence
    zero_on_a: assert property (motor_speed < 10 && motor_speed > -10 |=> zero_speed_flag)
        else $error("zero flag low");
    zero_off_a: assert property (motor_speed > 200 || motor_speed < -200 |=> !zero_speed_flag)
        else $error("zero flag high");
    band_exit_a: assert property (off_band_s |=> !velocity_consistent_flag)
        else $error("consistent flag high");
    vel_mode_a: assert property (
        velocity_consistent_flag |-> $past(control_mode) == `SMSO_MODE_VEL)
        else $error("consistent flag out of mode");
    trq_mode_a: assert property (
        torque_reached_flag |-> $past(control_mode) == `SMSO_MODE_TRQ)
        else $error("torque flag out of mode");
    pos_dir_a: assert property (positive_limit_alarm |-> $past(motor_speed) > 0)
        else $error("positive alarm wrong way");
    neg_dir_a: assert property (negative_limit_alarm |-> $past(motor_speed) < 0)
        else $error("negative alarm wrong way");
    estop_app_a: assert property (!$past(srst) && $past(estop_input) |->
        estop_method_applied == $past(estop_method_select))
        else $error("stop method not applied");
endmodule // smso_status_properties

/* File: bench/smso_ctrl_model.sv */
`timescale 1ns/1ps
// controller side: one-cycle parameter write strobes
module smso_ctrl_model (
    input wire clk_sys,
    input wire param_reject,
    output reg param_write,
    output reg [3:0] param_select,
    output reg [31:0] param_data
);
    reg rejected;
    // idle at time zero
    initial begin
        param_write = 1'b0;
        param_select = 4'h0;
        param_data = 32'h0000_0000;
        rejected = 1'b0;
    end
    // strobe one word, refusal read in the cycle after
    task put(input [3:0] sel, input [31:0] data);
        begin
            @(posedge clk_sys);
            param_write <= 1'b1;
            param_select <= sel;
            param_data <= data;
            @(posedge clk_sys);
            param_write <= 1'b0;
            param_data <= ~data; // no stale word on idle data
            #1 rejected = param_reject;
        end
    endtask
endmodule // smso_ctrl_model

/* File: bench/tb_smso_status.sv */
`timescale 1ns/1ps
`include "smso_consts.vh"
module tb_smso_status;
    localparam ZS = 6, VC = 5, VR = 4, TR = 3, PC = 2, PA = 1, NA = 0;
    reg clk_sys = 1'b0;
    reg srst = 1'b1;
    reg [1:0] mode = 2'd3;
    reg signed [31:0] spd = 0, cmd = 0, trq = 0, pos = 0;
    reg estop = 1'b0;
    wire wr_en, rej, zs, vc, vr, tr, pc, pa, na, clamp;
    wire [3:0] sel, es_sel, es_app;
    wire [31:0] wdata;
    wire [7:0] home;
    wire [6:0] fl = {zs, vc, vr, tr, pc, pa, na};
    integer bad_count = 0;
    integer samples_checked = 0;
    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;
    smso_ctrl_model smso_ctrl_model_inst (.clk_sys(clk_sys), .param_reject(rej),
        .param_write(wr_en), .param_select(sel), .param_data(wdata));
    smso_status #(.CYC_PER_MS(4)) smso_status_inst (.clk_sys(clk_sys), .srst(srst),
        .control_mode(mode), .motor_speed(spd), .speed_command(cmd), .motor_torque(trq),
        .motor_position(pos), .estop_input(estop), .param_write(wr_en), .param_select(sel),
        .param_data(wdata), .zero_speed_flag(zs), .velocity_consistent_flag(vc),
        .velocity_reached_flag(vr), .torque_reached_flag(tr), .position_coincidence_flag(pc),
        .positive_limit_alarm(pa), .negative_limit_alarm(na), .homing_method_select(home),
        .estop_method_select(es_sel), .estop_method_applied(es_app),
        .zero_clamp_enable(clamp), .param_reject(rej));
    // compare one result
    task check(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
            end
        end
    endtask
    // wait edges, then let updates land
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    // keep inputs, then look at one flag
    task hold(input integer n, f, input e);
        begin
            cyc(n);
            check(fl[f], e);
        end
    endtask
    // apply a motion sample, then look at one flag
    task pk(input [1:0] m, input signed [31:0] s, c, t, p, input integer n, f, input e);
        begin
            @(posedge clk_sys);
            mode <= m;
            spd <= s;
            cmd <= c;
            trq <= t;
            pos <= p;
            hold(n, f, e);
        end
    endtask
    // parameter write with expected refusal
    task wr(input [3:0] s, input [31:0] d, input r);
        begin
            smso_ctrl_model_inst.put(s, d);
            check(smso_ctrl_model_inst.rejected, r);
        end
    endtask
    // defaults and zero speed in every mode
    task t_zero;
        integer m;
        begin
            check(home, 8'h01);
            check(es_sel, 4'h5);
            check(clamp, 1'b0);
            for (m = 0; m < 4; m = m + 1) begin
                pk(m[1:0], 49, 0, 0, 0, 1, ZS, 1);
                pk(m[1:0], -51, 0, 0, 0, 1, ZS, 0);
            end
            wr(`SMSO_SEL_ZS_THR, 100, 0);
            pk(3, -99, 0, 0, 0, 1, ZS, 1);
            wr(`SMSO_SEL_ZS_THR, 201, 1);
            wr(4'hC, 0, 1);
        end
    endtask
    // velocity mode qualification
    task t_vel;
        begin
            wr(`SMSO_SEL_TIMER, 3, 0);
            pk(1, 500, 505, 0, 0, 6, VC, 0);
            hold(12, VC, 1);
            pk(1, 500, 511, 0, 0, 1, VC, 0);
            pk(1, 500, 490, 0, 0, 6, VC, 0);
            pk(1, 1500, 20000, 0, 0, 11, VR, 0);
            hold(60, VR, 1);
            pk(2, 1500, 1500, 0, 0, 1, VR, 0);
        end
    endtask
    // torque mode qualification
    task t_trq;
        begin
            wr(`SMSO_SEL_TTGT, 300, 0);
            wr(`SMSO_SEL_TBAND, 100, 0);
            pk(2, 0, 0, 250, 0, 20, TR, 0);
            pk(2, 0, 0, 305, 0, 6, TR, 0);
            hold(12, TR, 1);
            pk(2, 0, 0, 401, 0, 1, TR, 0);
        end
    endtask
    // coincidence window and soft limits
    task t_pos;
        begin
            pk(0, 0, 0, 0, 10100, 1, PC, 1);
            pk(0, 0, 0, 0, 9899, 1, PC, 0);
            wr(`SMSO_SEL_PLIM, 1000, 0);
            pk(0, 10, 0, 0, 1000, 1, PA, 1);
            pk(0, -10, 0, 0, 1000, 1, PA, 0);
            wr(`SMSO_SEL_NLIM, -1000, 0);
            pk(0, -10, 0, 0, -1000, 1, NA, 1);
            pk(0, -10, 0, 0, -999, 1, NA, 0);
            @(posedge clk_sys);
            srst <= 1'b1;
            @(posedge clk_sys);
            srst <= 1'b0;
            pk(0, 10, 0, 0, 1, 1, PA, 1);
        end
    endtask
    // selector ranges and stop method use
    task t_sel;
        begin
            wr(`SMSO_SEL_HOME, -4, 0);
            check(home, 8'hFC);
            wr(`SMSO_SEL_HOME, 41, 1);
            wr(`SMSO_SEL_HOME, 40, 0);
            check(home, 8'h28);
            wr(`SMSO_SEL_ESTOP, 8, 0);
            wr(`SMSO_SEL_ESTOP, 9, 1);
            check(es_sel, 4'h8);
            @(posedge clk_sys);
            estop <= 1'b1;
            cyc(2);
            check(es_app, 4'h8);
            wr(`SMSO_SEL_CLAMP, 1, 0);
            check(clamp, 1'b1);
            wr(`SMSO_SEL_CLAMP, 2, 1);
            wr(`SMSO_SEL_TIMER, 30001, 1);
            wr(`SMSO_SEL_TIMER, 30000, 0);
        end
    endtask
    // counts and verdict
    task give_verdict;
        begin
            $display("compares %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        cyc(2);
        t_zero;
        t_vel;
        t_trq;
        t_pos;
        t_sel;
        give_verdict;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count = bad_count + 1;
        give_verdict;
    end
endmodule // tb_smso_status
bind smso_status smso_status_properties smso_status_properties_inst (.clk_sys(clk_sys),
    .srst(srst), .control_mode(control_mode), .motor_speed(motor_speed),
    .speed_command(speed_command), .estop_input(estop_input),
    .zero_speed_flag(zero_speed_flag), .velocity_consistent_flag(velocity_consistent_flag),
    .torque_reached_flag(torque_reached_flag), .positive_limit_alarm(positive_limit_alarm),
    .negative_limit_alarm(negative_limit_alarm), .estop_method_select(estop_method_select),
    .estop_method_applied(estop_method_applied));
